// ==== hw/ddsmc_core.sv ====
`timescale 1ns/1ps
module ddsmc_core
    import ddsmc_pkg::*;
#(
    parameter int ACC_W = 48,
    parameter int PH_W  = 17
)(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              resetn,
    // parallel port
    input  wire logic              read_strobe_n,
    input  wire logic              write_strobe_n,
    input  wire logic [ADDR_W-1:0] port_address,
    input  wire logic [7:0]        port_data_in,
    output logic      [7:0]        port_data_out,
    output logic                   port_data_oe,
    // serial port
    input  wire logic              serial_select_n,
    input  wire logic              sclk,
    input  wire logic              serial_data,
    // control pins
    input  wire ddsmc_pins_t       pins,
    // datapath outputs
    output logic      [PH_W-1:0]   phase_out,
    output logic      [11:0]       i_amp,
    output logic      [11:0]       q_amp,
    output logic      [11:0]       ctrl_dac,
    output ddsmc_pwr_t             pwr
);
    // ==========================================
    // pin synchronisers
    ddsmc_pins_t       pins_m, pins_s;
    logic [1:0]        rw_m, rw_s;
    logic [ADDR_W-1:0] pa_m, pa_s;
    logic [7:0]        pd_m, pd_s;
    logic              wr_n_q, upd_q, rst_n_q;
    always_ff @(posedge mclk)
    begin
        pins_m <= pins;
        pins_s <= pins_m;
        rw_m   <= {read_strobe_n, write_strobe_n};
        rw_s   <= rw_m;
        pa_m   <= port_address;
        pa_s   <= pa_m;
        pd_m   <= port_data_in;
        pd_s   <= pd_m;
    end
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            wr_n_q  <= 1'b1;
            upd_q   <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            wr_n_q  <= rw_s[0];
            upd_q   <= pins_s.io_update;
            rst_n_q <= 1'b1;
        end
    end
    wire logic par_wr = pins_s.parallel_mode && rw_s[0] && !wr_n_q;
    wire logic update = pins_s.io_update && !upd_q;
    // ==========================================
    // serial receiver on the link clock
    // select high clears the framing; the frame's own signal ends it
    logic [2:0]        sbit_q;
    logic [6:0]        ssh_q;
    logic              shdr_q;
    logic [ADDR_W-1:0] saddr_q, sx_addr_q;
    logic [7:0]        sx_data_q;
    logic              stog_q = 1'b0;
    always_ff @(posedge sclk or posedge serial_select_n)
    begin
        if (serial_select_n)
        begin
            sbit_q <= 3'h0;
            shdr_q <= 1'b1;
            ssh_q  <= 7'h00;
        end
        else
        begin
            sbit_q <= sbit_q + 3'h1;
            ssh_q  <= {ssh_q[5:0], serial_data};
            if (sbit_q == 3'h7)
                shdr_q <= 1'b0;
        end
    end
    // byte address and hand-off word survive the end of a frame
    always_ff @(posedge sclk)
    begin
        if (sbit_q == 3'h7 && !serial_select_n)
        begin
            if (shdr_q)
                saddr_q <= {ssh_q[ADDR_W-2:0], serial_data};
            else
            begin
                sx_addr_q <= saddr_q;
                sx_data_q <= {ssh_q, serial_data};
                stog_q    <= ~stog_q;
                saddr_q   <= saddr_q + 6'h01;
            end
        end
    end
    // toggle crossing; address and data stay still for eight link clocks
    logic [2:0] stog_m;
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            stog_m <= 3'h0;
        else
            stog_m <= {stog_m[1:0], stog_q};
    end
    wire logic ser_wr = !pins_s.parallel_mode && (stog_m[2] ^ stog_m[1]);
    // ==========================================
    // port buffer and working registers
    logic [7:0] buf_q [NBYTES];
    logic [7:0] wrk_q [NBYTES];
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NBYTES; i++)
        begin
            if (!resetn)
                buf_q[i] <= def_byte(6'(i));
            else if (par_wr && pa_s == 6'(i))
                buf_q[i] <= pd_s;
            else if (ser_wr && sx_addr_q == 6'(i))
                buf_q[i] <= sx_data_q;
        end
    end
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NBYTES; i++)
        begin
            if (!resetn)
                wrk_q[i] <= def_byte(6'(i));
            else if (update)
                wrk_q[i] <= buf_q[i];
        end
    end
    // parallel readback of the buffer; addresses from NBYTES up read zero
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            port_data_out <= 8'h00;
        else if (pa_s < 6'(NBYTES))
            port_data_out <= buf_q[pa_s];
        else
            port_data_out <= 8'h00;
    end
    assign port_data_oe = rst_n_q && pins_s.parallel_mode && !rw_s[1];
    // ==========================================
    // field views, most significant byte at the lowest address
    function automatic logic [47:0] w48(input logic [5:0] b);
        w48 = {wrk_q[b], wrk_q[b+6'h1], wrk_q[b+6'h2], wrk_q[b+6'h3], wrk_q[b+6'h4], wrk_q[b+6'h5]};
    endfunction
    function automatic logic [11:0] w12(input logic [5:0] b);
        w12 = {wrk_q[b][3:0], wrk_q[b+6'h1]};
    endfunction
    function automatic logic [13:0] w14(input logic [5:0] b);
        w14 = {wrk_q[b][5:0], wrk_q[b+6'h1]};
    endfunction
    ddsmc_mode_t mode;
    logic [47:0] ftw1, ftw2, dfw;
    logic [19:0] rr20;
    logic [7:0]  rr8, opt, ctl;
    logic [11:0] imul, qmul;
    assign mode = ddsmc_mode_t'(wrk_q[A_MODE][B_MODE+:3]);
    assign ftw1 = w48(A_FTW1);
    assign ftw2 = w48(A_FTW2);
    assign dfw  = w48(A_DFW);
    assign rr20 = {wrk_q[A_RR20][3:0], wrk_q[A_RR20+6'h1], wrk_q[A_RR20+6'h2]};
    assign rr8  = wrk_q[A_OSKR];
    assign opt  = wrk_q[A_OPT];
    assign ctl  = wrk_q[A_MODE];
    assign imul = w12(A_IMUL);
    assign qmul = w12(A_QMUL);
    wire logic ramped = (mode == M_RFSK) || (mode == M_CHIRP);
    wire logic hold   = (mode == M_CHIRP) && pins_s.keying;
    wire logic osk_en = opt[B_OSKEN];
    wire logic osk_sh = osk_en && opt[B_OSKINT];
    // ==========================================
    // 20-bit ramp-rate counter
    // a reload of at least one keeps the step rate within the accumulator limit
    logic [19:0] rc20_q;
    logic        p20;
    wire  logic [19:0] rl20 = (rr20 < 20'(MIN_STEP_CYC - 1)) ? 20'(MIN_STEP_CYC - 1) : rr20;
    assign p20 = ramped && !hold && rc20_q == 20'h00000;
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            rc20_q <= 20'h00000;
        else if (!ramped)
            rc20_q <= rl20;
        else if (!hold)
            rc20_q <= (rc20_q == 20'h00000) ? rl20 : rc20_q - 20'h1;
    end
    // ==========================================
    // frequency accumulator and tuning path
    logic [47:0] facc_q;
    logic [47:0] tw_sel, tw_in;
    logic        clr1_q;
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            clr1_q <= 1'b0;
        else
            clr1_q <= update && buf_q[A_MODE][B_CLR1];
    end
    always_ff @(posedge mclk)
    begin
        if (!resetn || ctl[B_CLR2] || clr1_q || !ramped)
            facc_q <= 48'h0;
        else if (p20)
            facc_q <= facc_q + dfw;
    end
    assign tw_sel = (mode == M_FSK && pins_s.keying) ? ftw2 : ftw1;
    assign tw_in  = ramped ? tw_sel + facc_q : tw_sel;
    // ==========================================
    // phase accumulator and offset
    logic [ACC_W-1:0] pacc_q;
    logic [13:0]      poff;
    always_ff @(posedge mclk)
    begin
        if (!resetn || ctl[B_CLR2])
            pacc_q <= '0;
        else
            pacc_q <= pacc_q + ACC_W'(tw_in);
    end
    assign poff = (mode == M_BPSK && pins_s.keying) ? w14(A_PH2) : w14(A_PH1);
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            phase_out <= '0;
        else
            phase_out <= pacc_q[ACC_W-1 -: PH_W] + {poff, 3'h0};
    end
    // ==========================================
    // 8-bit ramp-rate counter and shaped keying
    logic [7:0]  rc8_q;
    logic        p8;
    logic [11:0] ish_q, qsh_q;
    assign p8 = osk_sh && rc8_q == 8'h00;
    always_ff @(posedge mclk)
    begin
        if (!resetn || !osk_sh)
            rc8_q <= rr8;
        else
            rc8_q <= (rc8_q == 8'h00) ? rr8 : rc8_q - 8'h01;
    end
    function automatic logic [11:0] step(input logic [11:0] v, input logic [11:0] t, input logic up);
        if (up && v < t)
            step = v + 12'h001;
        else if (up && v > t)
            step = t;
        else if (!up && v != 12'h000)
            step = v - 12'h001;
        else
            step = v;
    endfunction
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            ish_q <= 12'h000;
            qsh_q <= 12'h000;
        end
        else if (p8)
        begin
            ish_q <= step(ish_q, imul, pins_s.shape_key);
            qsh_q <= step(qsh_q, qmul, pins_s.shape_key);
        end
    end
    // ==========================================
    // amplitude outputs; control converter skips the shaping
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            i_amp    <= 12'h000;
            q_amp    <= 12'h000;
            ctrl_dac <= 12'h000;
        end
        else
        begin
            i_amp    <= !osk_en ? 12'hFFF : osk_sh ? ish_q : imul;
            q_amp    <= !osk_en ? 12'hFFF : osk_sh ? qsh_q : qmul;
            ctrl_dac <= w12(A_CDAC);
        end
    end
    // ==========================================
    // power control
    logic [7:0] pwb;
    assign pwb = wrk_q[A_PWR];
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            pwr <= '0;
        else
        begin
            pwr.comp_sleep      <= pwb[B_COMP];
            pwr.ctrl_dac_sleep  <= pwb[B_CDAC];
            pwr.dac_sleep       <= pwb[B_DAC];
            pwr.dig_sleep       <= pwb[B_DIG];
            pwr.full_sleep      <= pwb[B_COMP] && pwb[B_CDAC] && pwb[B_DAC] && pwb[B_DIG];
            pwr.inv_sinc_bypass <= opt[B_INVS];
            pwr.mult_bypass     <= !osk_en;
        end
    end
endmodule

// ==== hw/ddsmc_pkg.sv ====
package ddsmc_pkg;
    // ==========================================
    // port geometry and byte map
    localparam int         ADDR_W   = 6;
    localparam int         NBYTES   = 40;
    localparam logic [5:0] A_PH1    = 6'h00;
    localparam logic [5:0] A_PH2    = 6'h02;
    localparam logic [5:0] A_FTW1   = 6'h04;
    localparam logic [5:0] A_FTW2   = 6'h0A;
    localparam logic [5:0] A_DFW    = 6'h10;
    localparam logic [5:0] A_UPD_LO = 6'h19;
    localparam logic [5:0] A_RR20   = 6'h1A;
    localparam logic [5:0] A_PWR    = 6'h1D;
    localparam logic [5:0] A_PLL    = 6'h1E;
    localparam logic [5:0] A_MODE   = 6'h1F;
    localparam logic [5:0] A_OPT    = 6'h20;
    localparam logic [5:0] A_IMUL   = 6'h21;
    localparam logic [5:0] A_QMUL   = 6'h23;
    localparam logic [5:0] A_OSKR   = 6'h25;
    localparam logic [5:0] A_CDAC   = 6'h26;
    // ==========================================
    // reset values that are not zero
    localparam logic [7:0] DEF_UPD_LO = 8'h40;
    localparam logic [7:0] DEF_PLL    = 8'h64;
    localparam logic [7:0] DEF_MODE   = 8'h01;
    localparam logic [7:0] DEF_OPT    = 8'h20;
    localparam logic [7:0] DEF_OSKR   = 8'h80;
    // ==========================================
    // field positions
    localparam int B_CLR1   = 7;
    localparam int B_CLR2   = 6;
    localparam int B_MODE   = 1;
    localparam int B_INVS   = 6;
    localparam int B_OSKEN  = 5;
    localparam int B_OSKINT = 4;
    localparam int B_COMP   = 4;
    localparam int B_CDAC   = 2;
    localparam int B_DAC    = 1;
    localparam int B_DIG    = 0;
    localparam int B_RD     = 7;
    // ==========================================
    // timing
    localparam longint CLK_HZ      = 200_000_000;
    localparam longint STEP_MAX_HZ = 150_000_000;
    localparam int     MIN_STEP_CYC = int'((CLK_HZ + STEP_MAX_HZ - 1) / STEP_MAX_HZ);
    localparam int     RST_MIN_CYC  = 10;
    // ==========================================
    // modes (codes fixed by the control byte)
    typedef enum logic [2:0] {
        M_SINGLE = 3'h0,
        M_FSK    = 3'h1,
        M_RFSK   = 3'h2,
        M_CHIRP  = 3'h3,
        M_BPSK   = 3'h4
    } ddsmc_mode_t;
    typedef struct packed {
        logic parallel_mode;
        logic keying;
        logic shape_key;
        logic io_update;
    } ddsmc_pins_t;
    typedef struct packed {
        logic comp_sleep;
        logic ctrl_dac_sleep;
        logic dac_sleep;
        logic dig_sleep;
        logic full_sleep;
        logic inv_sinc_bypass;
        logic mult_bypass;
    } ddsmc_pwr_t;
    function automatic logic [7:0] def_byte(input logic [5:0] a);
        case (a)
            A_UPD_LO: def_byte = DEF_UPD_LO;
            A_PLL:    def_byte = DEF_PLL;
            A_MODE:   def_byte = DEF_MODE;
            A_OPT:    def_byte = DEF_OPT;
            A_OSKR:   def_byte = DEF_OSKR;
            default:  def_byte = 8'h00;
        endcase
    endfunction
endpackage

// ==== testbench/ddsmc_chk_sva.sv ====
`timescale 1ns/1ps
module ddsmc_chk
    import ddsmc_pkg::*;
#(
    parameter int PH_W = 17
)(
    // clock and reset
    input wire logic              mclk,
    input wire logic              resetn,
    // programming port
    input wire logic              read_strobe_n,
    input wire logic              write_strobe_n,
    input wire logic [ADDR_W-1:0] port_address,
    input wire logic [7:0]        port_data_in,
    input wire logic [7:0]        port_data_out,
    input wire logic              port_data_oe,
    input wire logic              serial_select_n,
    input wire logic              sclk,
    input wire logic              serial_data,
    // pins and datapath
    input wire ddsmc_pins_t       pins,
    input wire logic [PH_W-1:0]   phase_out,
    input wire logic [11:0]       i_amp,
    input wire logic [11:0]       q_amp,
    input wire logic [11:0]       ctrl_dac,
    input wire ddsmc_pwr_t        pwr
);
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // ==========================================
    // port
    chk_oe_serial_off: assert property ((!pins.parallel_mode)[*4] |-> !port_data_oe)
        else $error("read enable driven in serial mode");
    chk_oe_read_on: assert property ((pins.parallel_mode && !read_strobe_n)[*4] |-> port_data_oe)
        else $error("read enable missing during read");
    chk_oe_idle_off: assert property (read_strobe_n[*4] |-> !port_data_oe)
        else $error("read enable without read strobe");
    chk_buf_holds: assert property ((!read_strobe_n && write_strobe_n && $stable(port_address))[*5]
        |-> $stable(port_data_out))
        else $error("buffer byte changed without a write");
    // ==========================================
    // working registers only move after an update
    chk_pwr_hold: assert property ((!pins.io_update)[*8] |-> $stable(pwr))
        else $error("power controls changed without update");
    chk_cdac_unshaped: assert property ((!pins.io_update)[*8] |-> $stable(ctrl_dac))
        else $error("control converter value moved");
    chk_amp_step: assert property ((!pins.io_update)[*8] |->
        ((i_amp - $past(i_amp) + 12'h001) <= 12'h002) && ((q_amp - $past(q_amp) + 12'h001) <= 12'h002))
        else $error("amplitude moved by more than one step");
    chk_full_sleep: assert property (pwr.full_sleep ==
        (pwr.comp_sleep && pwr.ctrl_dac_sleep && pwr.dac_sleep && pwr.dig_sleep))
        else $error("full sleep disagrees with stage bits");
endmodule

// ==== testbench/ddsmc_host.sv ====
`timescale 1ns/1ps
module ddsmc_host
    import ddsmc_pkg::*;
(
    // clock and readback
    input  wire logic              mclk,
    input  wire logic [7:0]        port_data_out,
    input  wire logic              port_data_oe,
    // parallel port
    output logic                   read_strobe_n,
    output logic                   write_strobe_n,
    output logic      [ADDR_W-1:0] port_address,
    output logic      [7:0]        port_data_in,
    // serial port
    output logic                   serial_select_n,
    output logic                   sclk,
    output logic                   serial_data,
    // read result
    output logic                   rd_done,
    output logic      [7:0]        rd_byte
);
    initial
    begin
        {read_strobe_n, write_strobe_n, serial_select_n} = 3'h7;
        {sclk, serial_data, rd_done} = 3'h0;
        port_address = 6'h00;
        port_data_in = 8'h00;
        rd_byte = 8'h00;
    end
    // ==========================================
    // parallel cycles; data held past release because the pins are resynchronised
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        port_address <= a;
        port_data_in <= d;
        write_strobe_n <= 1'b0;
        repeat (3) @(posedge mclk);
        write_strobe_n <= 1'b1;
        repeat (5) @(posedge mclk);
        port_data_in <= ~d;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge mclk);
        port_address <= a;
        read_strobe_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rd_byte <= port_data_oe ? port_data_out : 8'hXX;
        rd_done <= 1'b1;
        read_strobe_n <= 1'b1;
        @(posedge mclk);
        rd_done <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    // ==========================================
    // serial frame: address header then one byte; link clock only runs inside it
    task automatic sw(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] f;
        f = {2'b00, a, d};
        #3 serial_select_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            serial_data = f[i];
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        #24 serial_select_n = 1'b1;
        serial_data = ~f[0];
        repeat (8) @(posedge mclk);
    endtask
endmodule

// ==== testbench/tb_dds_modulation_control.sv ====
`timescale 1ns/1ps
module tb_dds_modulation_control;
    import ddsmc_pkg::*;
    localparam int PH_W = 17;
    typedef struct packed {
        logic [2:0]  src;
        logic [16:0] v;
    } ddsmc_exp_t;
    // ==========================================
    // wiring
    logic              mclk, resetn, read_strobe_n, write_strobe_n, port_data_oe;
    logic              serial_select_n, sclk, serial_data, rd_done, snap;
    logic [5:0]        port_address;
    logic [7:0]        port_data_in, port_data_out, rd_byte, b, prev;
    logic [11:0]       i_amp, q_amp, ctrl_dac, m, meas, a0;
    logic [13:0]       p1, p2;
    logic [16:0]       got;
    logic [47:0]       w;
    logic [PH_W-1:0]   phase_out;
    ddsmc_pins_t       pins;
    ddsmc_pwr_t        pwr;
    ddsmc_exp_t        e;
    ddsmc_exp_t        q[$];
    int                fails, compares, cyc, seed;
    logic [7:0]        pat [5] = '{8'h10, 8'h04, 8'h02, 8'h01, 8'h17};
    logic [5:0]        da [7] = '{6'h00, 6'h19, 6'h1E, 6'h1F, 6'h20, 6'h25, 6'h3F};
    logic [7:0]        dv [7] = '{8'h00, 8'h40, 8'h64, 8'h01, 8'h20, 8'h80, 8'h00};
    string             nm [7] = '{"readback", "pwr", "i_amp", "ctrl_dac", "phase_out", "ramp_period", "q_amp"};

    ddsmc_core #(.PH_W(PH_W)) i_dut (.mclk(mclk), .resetn(resetn), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .port_address(port_address), .port_data_in(port_data_in),
        .port_data_out(port_data_out), .port_data_oe(port_data_oe), .serial_select_n(serial_select_n),
        .sclk(sclk), .serial_data(serial_data), .pins(pins), .phase_out(phase_out), .i_amp(i_amp),
        .q_amp(q_amp), .ctrl_dac(ctrl_dac), .pwr(pwr));
    ddsmc_host i_host (.mclk(mclk), .port_data_out(port_data_out), .port_data_oe(port_data_oe),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .port_address(port_address),
        .port_data_in(port_data_in), .serial_select_n(serial_select_n), .sclk(sclk),
        .serial_data(serial_data), .rd_done(rd_done), .rd_byte(rd_byte));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ==========================================
    // helpers
    function automatic logic [6:0] pwr_of(input logic [7:0] s, input logic [7:0] o);
        pwr_of = {s[4], s[2], s[1], s[0], s[4] & s[2] & s[1] & s[0], o[6], ~o[5]};
    endfunction
    task automatic look(input logic [2:0] s, input logic [16:0] v);
        q.push_back('{s, v});
        snap <= 1'b1;
        @(posedge mclk);
        snap <= 1'b0;
    endtask
    task automatic rdx(input logic [5:0] a, input logic [7:0] v);
        q.push_back('{3'h0, {9'h000, v}});
        i_host.rd(a);
    endtask
    task automatic upd;
        @(posedge mclk);
        pins.io_update <= 1'b1;
        repeat (4) @(posedge mclk);
        pins.io_update <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    // bounded wait; a timeout here shows up as a mismatch in the next look
    task automatic wait_amp(input logic [11:0] v);
        for (int i = 0; i < 600 && i_amp !== v; i++)
            @(posedge mclk);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================
    // result watcher
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            tally_and_finish;
        end
        if ((rd_done || snap) && q.size() > 0)
        begin
            e = q.pop_front();
            case (e.src)
                3'h0: got = {9'h000, rd_byte};
                3'h1: got = {10'h000, pwr};
                3'h2: got = {5'h00, i_amp};
                3'h3: got = {5'h00, ctrl_dac};
                3'h4: got = phase_out;
                3'h6: got = {5'h00, q_amp};
                default: got = {5'h00, meas};
            endcase
            compares++;
            if (got !== e.v)
            begin
                fails++;
                $display("BAD %s exp %h got %h", nm[e.src], e.v, got);
            end
        end
    end
    // ==========================================
    // main sequence
    initial
    begin
        resetn = 1'b0;
        pins = '{parallel_mode: 1'b1, keying: 1'b0, shape_key: 1'b0, io_update: 1'b0};
        {snap, fails, compares, cyc, meas} = '0;
        seed = $urandom(42670);
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 7; i++)
            rdx(da[i], dv[i]);
        look(3'h1, 17'h00000);
        $display("test defaults done");
        w = 48'({$urandom(), $urandom()});
        for (int i = 0; i < 6; i++)
            i_host.wr(A_FTW2 + 6'(i), w[47-8*i -: 8]);
        for (int i = 0; i < 6; i++)
            rdx(A_FTW2 + 6'(i), w[47-8*i -: 8]);
        $display("test byte order done");
        // host: blocked tuning byte, both phases, keying source, then update
        {p1, p2} = 28'($urandom());
        pins.parallel_mode <= 1'b0;
        i_host.wr(A_FTW2, ~w[47:40]);
        i_host.sw(A_PH1, {2'b00, p1[13:8]});
        i_host.sw(A_PH1 + 6'h01, p1[7:0]);
        pins.parallel_mode <= 1'b1;
        i_host.sw(A_PH2, 8'hFF);
        i_host.wr(A_PH2, {2'b00, p2[13:8]});
        i_host.wr(A_PH2 + 6'h01, p2[7:0]);
        rdx(A_FTW2, w[47:40]);
        rdx(A_PH1, {2'b00, p1[13:8]});
        rdx(A_PH2, {2'b00, p2[13:8]});
        i_host.wr(A_MODE, 8'h08);
        upd;
        look(3'h4, {p1, 3'b000});
        pins.keying <= 1'b1;
        repeat (6) @(posedge mclk);
        look(3'h4, {p2, 3'b000});
        $display("test phase keying done");
        prev = 8'h00;
        for (int i = 0; i < 5; i++)
        begin
            b = pat[i];
            i_host.wr(A_PWR, b);
            look(3'h1, 17'(pwr_of(prev, 8'h20)));
            upd;
            look(3'h1, 17'(pwr_of(b, 8'h20)));
            prev = b;
        end
        i_host.wr(A_OPT, 8'h40);
        upd;
        look(3'h1, 17'(pwr_of(prev, 8'h40)));
        look(3'h2, 17'h00FFF);
        $display("test power done");
        m = 12'($urandom());
        i_host.wr(A_IMUL, {4'h0, m[11:8]});
        i_host.wr(A_IMUL + 6'h01, m[7:0]);
        i_host.wr(A_QMUL, {4'h0, ~m[11:8]});
        i_host.wr(A_QMUL + 6'h01, ~m[7:0]);
        i_host.wr(A_OPT, 8'h20);
        upd;
        look(3'h2, {5'h00, m});
        look(3'h6, {5'h00, ~m});
        $display("test static amplitude done");
        i_host.wr(A_IMUL, 8'h00);
        i_host.wr(A_IMUL + 6'h01, 8'h10);
        i_host.wr(A_OSKR, 8'h03);
        i_host.wr(A_OPT, 8'h30);
        i_host.wr(A_CDAC, {4'h0, m[3:0]});
        i_host.wr(A_CDAC + 6'h01, m[11:4]);
        pins.shape_key <= 1'b1;
        upd;
        wait_amp(12'h001);
        a0 = i_amp;
        for (int i = 0; i < 50 && meas == 12'h000; i++)
        begin
            @(posedge mclk);
            if (i_amp !== a0)
                meas = 12'(i + 1);
        end
        look(3'h5, 17'h00004);
        wait_amp(12'h010);
        look(3'h2, 17'h00010);
        pins.shape_key <= 1'b0;
        wait_amp(12'h000);
        look(3'h2, 17'h00000);
        look(3'h3, {5'h00, m[3:0], m[11:4]});
        $display("test ramp done");
        repeat (10) @(posedge mclk);
        tally_and_finish;
    end
endmodule

bind ddsmc_core ddsmc_chk #(.PH_W(PH_W)) i_chk (.mclk(mclk), .resetn(resetn), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .port_address(port_address), .port_data_in(port_data_in),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe), .serial_select_n(serial_select_n),
    .sclk(sclk), .serial_data(serial_data), .pins(pins), .phase_out(phase_out), .i_amp(i_amp),
    .q_amp(q_amp), .ctrl_dac(ctrl_dac), .pwr(pwr));
